// ---- src/ioc_params.svh ----
/*
 * constants of the configurable i/o cell: register offsets, control
 * field positions, reset values and the soft start-up timing.
 * assumes a 25 MHz core clock and avalon byte addressing.
 */
`ifndef IOC_PARAMS_SVH
`define IOC_PARAMS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define IOC_ADDR_W 4
`define IOC_CTRL_ADDR 4'h0
`define IOC_STAT_ADDR 4'h4
`define IOC_CTRL_RESET 9'h000

// ----------------------------------------
// control fields
// ----------------------------------------
`define IOC_F_DIR_LO 0
`define IOC_F_DIR_HI 1
`define IOC_F_LATCH 2
`define IOC_F_CLK_INV 3
`define IOC_F_FAST 4
`define IOC_F_OPEN_DRAIN 5
`define IOC_F_FLOAT_NODE 6
`define IOC_F_FLOAT_INV 7
`define IOC_F_RELEASE 8

// ----------------------------------------
// timing
// ----------------------------------------
`define IOC_CLK_NS 40
`define IOC_SOFT_NS 200
`define IOC_SOFT_CYC ((`IOC_SOFT_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)

`endif

// ---- src/ioc_pkg.sv ----
/*
 * types of the configurable i/o cell: direction modes, start-up
 * states, configuration and boundary-scan carriers.
 * assumes ioc_params.svh for all numeric constants.
 */
package ioc_pkg;

	typedef enum logic [1:0] {
		IOC_DIR_IN = 2'h0,
		IOC_DIR_OUT = 2'h1,
		IOC_DIR_BIDIR = 2'h2,
		IOC_DIR_RSVD = 2'h3
	} ioc_dir_t;

	// gray path: config -> soft -> user
	typedef enum logic [1:0] {
		IOC_ST_CONFIG = 2'h0,
		IOC_ST_SOFT = 2'h1,
		IOC_ST_USER = 2'h3
	} ioc_state_t;

	typedef struct packed {
		logic release_out;
		logic float_inv;
		logic float_node;
		logic open_drain;
		logic fast;
		logic clk_inv;
		logic latch;
		ioc_dir_t dir;
	} ioc_cfg_t;

	typedef struct packed {
		logic extest;
		logic data;
		logic oe;
	} ioc_bscan_t;

endpackage

// ---- src/ioc_cell.sv ----
/*
 * one configurable i/o cell joining a single pin to the array:
 * two direct input paths, a flop/latch input store, a three-state
 * driver with open-drain use, soft start-up slew control and the
 * device-wide float line. configured over avalon-mm.
 * assumes pad and array inputs synchronous to clk_in; the pin wire
 * is resolved outside from pad_out/pad_oe_out.
 */
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
// Contract
// - the cell serves one pin and works as input, output or bidirectional.
// - two direct input paths bring the pin level into the array.
// - the input store is chosen as an edge flop or a level latch.
// - the flop form captures the pin on the rising edge of its clock.
// - the latch form passes the pin while its gate is high and holds while low.
// - the store clock or gate may be inverted for falling edge or low gate.
// - open drain drives data low and uses the output to steer the enable.
// - drivers default to slow slew and run fast only when chosen per pin.
// - the first activation after configuration runs at limited slew.
// - right after that activation each pin uses its own slew option.
// - the float line puts every user output in high impedance.
// - the float line has no effect during a boundary-scan external test.
// - the float line may come from a pin through an input buffer.
// - an optional inversion sits between that pin buffer and the float line.
// - the float line may instead come from any internal node.
`timescale 1ns/1ps
`include "ioc_params.svh"

module ioc_cell
	import ioc_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [`IOC_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe_out,
	output logic slew_fast_out,
	input wire logic out_data_in,
	input wire logic out_en_in,
	input wire logic store_clk_in,
	output logic direct_input_path_a_out,
	output logic direct_input_path_b_out,
	output logic store_data_out,
	input wire logic float_pin_in,
	input wire logic float_node_in,
	input wire ioc_bscan_t bscan_in
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic dir_drives(input ioc_dir_t d);
		dir_drives = (d == IOC_DIR_OUT) || (d == IOC_DIR_BIDIR);
	endfunction

	function automatic logic dir_senses(input ioc_dir_t d);
		// reserved code falls back to input only
		dir_senses = (d != IOC_DIR_OUT);
	endfunction

	localparam logic [3:0] SOFT_CYC = 4'(`IOC_SOFT_CYC);

	ioc_cfg_t cfg_reg;
	ioc_state_t state_reg;
	ioc_state_t state_next;
	logic [3:0] soft_cnt_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic float_buf_reg;
	logic store_clk_prev_reg;
	logic store_reg;
	logic path_a_reg;
	logic path_b_reg;
	logic pad_out_reg;
	logic pad_oe_reg;
	logic slew_reg;
	logic req;
	logic float_line;
	logic float_eff;
	logic user_oe;
	logic user_data;
	logic gate_lvl;
	logic store_edge;

	// ----------------------------------------
	// avalon slave
	// ----------------------------------------
	// one wait cycle: read data settle before waitrequest drops
	assign req = avs_read_in || avs_write_in;
	assign avs_waitrequest_out = req && !ack_reg;
	assign avs_readdata_out = rdata_reg;

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req && !ack_reg;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			cfg_reg <= ioc_cfg_t'(`IOC_CTRL_RESET);
		end else if (avs_write_in && ack_reg &&
			avs_address_in == `IOC_CTRL_ADDR) begin
			cfg_reg <= ioc_cfg_t'(avs_writedata_in[`IOC_F_RELEASE:0]);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			rdata_reg <= 32'h0000_0000;
		end else if (avs_read_in && !ack_reg) begin
			unique case (avs_address_in)
				`IOC_CTRL_ADDR: rdata_reg <= {23'h000000, cfg_reg};
				`IOC_STAT_ADDR: rdata_reg <= {25'h0000000, slew_reg,
					pad_oe_reg, float_eff, state_reg, store_reg, pad_in};
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// start-up sequencing
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			IOC_ST_CONFIG: begin
				if (cfg_reg.release_out) begin
					state_next = IOC_ST_SOFT;
				end
			end
			IOC_ST_SOFT: begin
				if (!cfg_reg.release_out) begin
					state_next = IOC_ST_CONFIG;
				end else if (soft_cnt_reg == SOFT_CYC - 4'h1) begin
					state_next = IOC_ST_USER;
				end
			end
			IOC_ST_USER: begin
				if (!cfg_reg.release_out) begin
					state_next = IOC_ST_CONFIG;
				end
			end
			default: state_next = IOC_ST_CONFIG;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state_reg <= IOC_ST_CONFIG;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			soft_cnt_reg <= 4'h0;
		end else if (state_reg == IOC_ST_SOFT) begin
			soft_cnt_reg <= soft_cnt_reg + 4'h1;
		end else begin
			soft_cnt_reg <= 4'h0;
		end
	end

	// ----------------------------------------
	// input side
	// ----------------------------------------
	// optional store clock inversion
	assign gate_lvl = store_clk_in ^ cfg_reg.clk_inv;
	assign store_edge = gate_lvl && !(store_clk_prev_reg ^ cfg_reg.clk_inv);

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			store_clk_prev_reg <= 1'b0;
		end else begin
			store_clk_prev_reg <= store_clk_in;
		end
	end

	// flop or latch chosen by config
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			store_reg <= 1'b0;
		end else if (cfg_reg.latch) begin
			if (gate_lvl) begin
				store_reg <= pad_in;
			end
		end else if (store_edge) begin
			store_reg <= pad_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			path_a_reg <= 1'b0;
			path_b_reg <= 1'b0;
		end else begin
			path_a_reg <= pad_in && dir_senses(cfg_reg.dir);
			path_b_reg <= pad_in && dir_senses(cfg_reg.dir);
		end
	end

	assign direct_input_path_a_out = path_a_reg;
	assign direct_input_path_b_out = path_b_reg;
	assign store_data_out = store_reg && dir_senses(cfg_reg.dir);

	// ----------------------------------------
	// global float
	// ----------------------------------------
	// pin source taken through an input buffer stage
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			float_buf_reg <= 1'b0;
		end else begin
			float_buf_reg <= float_pin_in;
		end
	end

	assign float_line = cfg_reg.float_node ? float_node_in :
		(float_buf_reg ^ cfg_reg.float_inv);
	// external test masks the float line
	assign float_eff = float_line && !bscan_in.extest;

	// ----------------------------------------
	// output side
	// ----------------------------------------
	// open drain: data low, output steers enable
	assign user_data = cfg_reg.open_drain ? 1'b0 : out_data_in;
	// only output modes may drive after release
	assign user_oe = (state_reg != IOC_ST_CONFIG) &&
		dir_drives(cfg_reg.dir) &&
		(cfg_reg.open_drain ? !out_data_in : out_en_in);

	// enable gated by float unless external test
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			pad_out_reg <= 1'b0;
			pad_oe_reg <= 1'b0;
		end else if (bscan_in.extest) begin
			pad_out_reg <= bscan_in.data;
			pad_oe_reg <= bscan_in.oe;
		end else begin
			pad_out_reg <= user_data;
			pad_oe_reg <= user_oe && !float_eff;
		end
	end

	// user phase follows the pin option
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			slew_reg <= 1'b0;
		end else begin
			slew_reg <= (state_reg == IOC_ST_USER) && cfg_reg.fast;
		end
	end

	assign pad_out = pad_out_reg;
	assign pad_oe_out = pad_oe_reg;
	assign slew_fast_out = slew_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_input_only_quiet: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(cfg_reg.dir == IOC_DIR_IN && !bscan_in.extest) |=> !pad_oe_out)
		else $error("input-only pin drove");

	a_direct_path_a: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(cfg_reg.dir == IOC_DIR_BIDIR) |=>
		direct_input_path_a_out == $past(pad_in) &&
		direct_input_path_b_out == $past(pad_in))
		else $error("direct path mismatch");

	a_flop_capture: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(!cfg_reg.latch && !cfg_reg.clk_inv && store_clk_in &&
		!store_clk_prev_reg) |=> store_reg == $past(pad_in))
		else $error("flop missed rising edge");

	a_flop_hold: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(!cfg_reg.latch && !store_edge) |=> $stable(store_reg))
		else $error("flop changed without edge");

	a_latch_hold: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(cfg_reg.latch && !cfg_reg.clk_inv && !store_clk_in)
		|=> $stable(store_reg))
		else $error("latch not holding");

	a_latch_inv_pass: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(cfg_reg.latch && cfg_reg.clk_inv && !store_clk_in)
		|=> store_reg == $past(pad_in))
		else $error("inverted latch not transparent");

	a_open_drain_pull: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(cfg_reg.open_drain && state_reg == IOC_ST_USER &&
		dir_drives(cfg_reg.dir) && !float_eff && !bscan_in.extest)
		|=> !pad_out && (pad_oe_out == !$past(out_data_in)))
		else $error("open drain level wrong");

	a_soft_slow: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(state_reg == IOC_ST_CONFIG && cfg_reg.release_out && cfg_reg.fast)
		|=> state_reg == IOC_ST_SOFT ##1 !slew_fast_out [*4])
		else $error("first activation not slew limited");

	a_user_slew: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(state_reg == IOC_ST_USER) |=> slew_fast_out == $past(cfg_reg.fast))
		else $error("slew not per pin");

	a_slow_default: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		!cfg_reg.fast |=> !slew_fast_out)
		else $error("fast slew without option");

	a_float_quiet: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		float_eff |=> !pad_oe_out)
		else $error("float did not release pin");

	a_extest_owns: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		bscan_in.extest |=> pad_oe_out == $past(bscan_in.oe) &&
		pad_out == $past(bscan_in.data))
		else $error("extest lost the pin");

	a_float_pin_inv: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(!cfg_reg.float_node && !bscan_in.extest && $past(nrst_in)) |->
		float_eff == ($past(float_pin_in) ^ cfg_reg.float_inv))
		else $error("float polarity wrong");

endmodule

// ---- bench/ioc_pin_model.sv ----
/*
 * far side of the cell: the package pin with a weak pull-up and an
 * optional outside driver.
 * assumes pad_out/pad_oe come from the cell; one driver at a time.
 */
`timescale 1ns/1ps

module ioc_pin_model (
	input wire logic pad_out_in,
	input wire logic pad_oe_in,
	input wire logic ext_en_in,
	input wire logic ext_val_in,
	output logic pin_out
);
	// ------
	// wire level
	// ------
	// pull-up, contention
	// a fight shows as unknown, never a quiet win
	always_comb begin
		if (pad_oe_in && ext_en_in)
			pin_out = 1'bx;
		else if (pad_oe_in)
			pin_out = pad_out_in;
		else if (ext_en_in)
			pin_out = ext_val_in;
		else
			pin_out = 1'b1;
	end
endmodule

// ---- bench/ioc_cell_bench.sv ----
/*
 * bench of the i/o cell: avalon master, array stimulus, pin checks.
 * assumes ioc_cell and ioc_pin_model; one 25 MHz clock.
 */
`timescale 1ns/1ps
`include "ioc_params.svh"

module ioc_cell_bench
	import ioc_pkg::*;
;
	logic clk = 0, nrst = 0, rd = 0, wr = 0, od = 1, oen = 1, sclk = 0;
	logic fp = 0, fn = 0, xe = 0, xv = 0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wd = 32'h0, seed = 32'hAAFE7682;
	ioc_bscan_t bs = '0;
	logic [31:0] rdata;
	logic wt, po, poe, sf, pa, pb, sd, pin;
	int errors = 0, total_checks = 0;
	logic [31:0] rq[$];

	always #20 clk = ~clk;

	ioc_cell i_dut(.clk_in(clk), .nrst_in(nrst), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wt), .pad_in(pin),
		.pad_out(po), .pad_oe_out(poe), .slew_fast_out(sf),
		.out_data_in(od), .out_en_in(oen), .store_clk_in(sclk),
		.direct_input_path_a_out(pa), .direct_input_path_b_out(pb),
		.store_data_out(sd), .float_pin_in(fp), .float_node_in(fn),
		.bscan_in(bs));
	ioc_pin_model i_pin(.pad_out_in(po), .pad_oe_in(poe), .ext_en_in(xe),
		.ext_val_in(xv), .pin_out(pin));

	// ------
	// helpers
	// ------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic st(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic cmp_word(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic r, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		logic w;
		n = 0;
		w = 1'b1;
		addr <= a;
		wd <= d;
		rd <= r;
		wr <= ~r;
		while (w && n < 20) begin
			@(posedge clk);
			n++;
			w = (wt !== 1'b0);
		end
		rd <= 1'b0;
		wr <= 1'b0;
		if (w) begin
			errors++;
			finish_test();
		end
		@(posedge clk);
	endtask
	task automatic wrc(input logic [31:0] d);
		bus(1'b0, `IOC_CTRL_ADDR, d);
	endtask
	task automatic rdx(input logic [3:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b1, a, 32'h0);
	endtask
	// read data taken at the edge where waitrequest is seen low
	always @(posedge clk) begin
		if (rd === 1'b1 && wt === 1'b0)
			cmp_word("readdata", rq.size() ? rq.pop_front() : 'x, rdata);
	end
	task automatic store(input logic lt, input logic inv);
		wrc({23'h0, 1'b1, 4'h0, inv, lt, 2'h0});
		xe <= 1'b1;
		xv <= 1'b1;
		sclk <= inv;
		st(4);
		sclk <= ~inv;
		st(4);
		chk("store", 1'b1, sd);
		xv <= 1'b0;
		st(4);
		chk("store", ~lt, sd);
		sclk <= inv;
		st(4);
		xv <= 1'b1;
		st(4);
		chk("store", ~lt, sd);
		sclk <= ~inv;
		st(4);
		chk("store", 1'b1, sd);
	endtask

	// ------
	// scenarios
	// ------
	initial begin
		st(5);
		chk("pad_oe", 1'b0, poe);
		nrst <= 1'b1;
		st(1);
		rdx(`IOC_CTRL_ADDR, 32'h0);
		wrc(32'hFFFFFFFF);
		rdx(`IOC_CTRL_ADDR, 32'h1FF);
		bus(1'b0, `IOC_STAT_ADDR, 32'h0);
		bus(1'b0, 4'h8, 32'h0);
		rdx(`IOC_CTRL_ADDR, 32'h1FF);
		rdx(4'h8, 32'h0);
		wrc(32'h001);
		st(3);
		chk("pad_oe", 1'b0, poe);
		wrc(32'h101);
		chk("slew", 1'b0, sf);
		st(10);
		chk("pad_oe", 1'b1, poe);
		chk("slew", 1'b0, sf);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			od <= seed[0];
			st(2);
			chk("pad_out", seed[0], po);
			chk("path_a", 1'b0, pa);
		end
		wrc(32'h011);
		wrc(32'h111);
		st(2);
		chk("slew", 1'b0, sf);
		st(8);
		chk("slew", 1'b1, sf);
		fp <= 1'b1;
		st(3);
		chk("pad_oe", 1'b0, poe);
		fp <= 1'b0;
		st(3);
		chk("pad_oe", 1'b1, poe);
		wrc(32'h191);
		st(3);
		chk("pad_oe", 1'b0, poe);
		fp <= 1'b1;
		st(3);
		chk("pad_oe", 1'b1, poe);
		wrc(32'h151);
		st(3);
		chk("pad_oe", 1'b1, poe);
		fn <= 1'b1;
		st(2);
		chk("pad_oe", 1'b0, poe);
		bs <= '{extest: 1'b1, data: 1'b0, oe: 1'b1};
		st(3);
		chk("pad_oe", 1'b1, poe);
		chk("pad_out", 1'b0, po);
		bs <= '0;
		st(3);
		chk("pad_oe", 1'b0, poe);
		fn <= 1'b0;
		fp <= 1'b0;
		oen <= 1'b0;
		od <= 1'b0;
		wrc(32'h122);
		st(10);
		chk("pad_oe", 1'b1, poe);
		chk("pin", 1'b0, pin);
		od <= 1'b1;
		st(3);
		chk("pad_oe", 1'b0, poe);
		chk("path_a", 1'b1, pa);
		chk("path_b", 1'b1, pb);
		oen <= 1'b1;
		xe <= 1'b1;
		wrc(32'h100);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			xv <= seed[1];
			st(3);
			chk("pad_oe", 1'b0, poe);
			chk("path_a", seed[1], pa);
			chk("path_b", seed[1], pb);
		end
		wrc(32'h103);
		st(3);
		chk("pad_oe", 1'b0, poe);
		for (int i = 0; i < 4; i++)
			store(i[1], i[0]);
		xe <= 1'b0;
		wrc(32'h101);
		st(10);
		rdx(`IOC_STAT_ADDR, 32'h0000002F);
		nrst <= 1'b0;
		st(2);
		chk("pad_oe", 1'b0, poe);
		nrst <= 1'b1;
		st(1);
		rdx(`IOC_CTRL_ADDR, 32'h0);
		st(3);
		chk("pad_oe", 1'b0, poe);
		if (rq.size() != 0)
			errors++;
		finish_test();
	end
endmodule
